// ### verilog/adsr_pkg.sv
/*
 * Shared constants and carrier types for the converter control block.
 * Assumes a single 50 MHz clock and a byte-wide register port.
 */
package adsr_pkg;
    localparam int CLK_MHZ = 50;
    // Register offsets (bank bit is address bit 7)
    localparam logic [7:0] ADDR_PORT_PINS = 8'h05;
    localparam logic [7:0] ADDR_CORE_IRQ = 8'h0B;
    localparam logic [7:0] ADDR_CORE_IRQ_HI = 8'h8B;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_RESULT = 8'h1E;
    localparam logic [7:0] ADDR_CONTROL = 8'h1F;
    localparam logic [7:0] ADDR_PORT_DIR = 8'h85;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h8C;
    localparam logic [7:0] ADDR_PIN_CFG = 8'h9F;
    // Field positions in conv_control
    localparam int CTL_ON = 0;
    localparam int CTL_GO = 2;
    localparam int CTL_CHS_LO = 3;
    localparam int CTL_CONV_CLOCK_SELECT_LO = 6;
    // Field positions elsewhere
    localparam int FLG_DONE = 6;
    localparam int CORE_GIE = 7;
    localparam int CORE_PERIPH_IRQ_EN = 6;
    // Reset values and implemented masks
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_CORE = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_PIN_CFG = 8'h00;
    localparam logic [7:0] RST_PORT_DIR = 8'h3F;
    localparam logic [7:0] MASK_CONTROL = 8'hDD;
    localparam logic [7:0] MASK_FLAGS = 8'h40;
    localparam logic [7:0] MASK_PIN_CFG = 8'h07;
    localparam logic [7:0] MASK_PORT_DIR = 8'h3F;
    localparam logic [7:0] MASK_PORT_PINS = 8'h3F;
    // Clock select codes
    localparam logic [1:0] CONV_CLOCK_SELECT_2 = 2'h0;
    localparam logic [1:0] CONV_CLOCK_SELECT_8 = 2'h1;
    localparam logic [1:0] CONV_CLOCK_SELECT_32 = 2'h2;
    localparam logic [1:0] CONV_CLOCK_SELECT_RC = 2'h3;
    // Timing in clk cycles
    localparam int TOSC_CYC = 1;
    localparam int INSTR_CYC = 4 * TOSC_CYC;
    localparam int RC_TAD_NS = 4000;
    localparam int RC_TAD_CYC = RC_TAD_NS * CLK_MHZ / 1000;
    localparam int HALF_TADS = 19;      // 9.5 bit periods in half periods
    localparam int WAIT_HALF_TADS = 4;  // 2 bit periods after abort
    localparam int CNT_W = 16;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adsr_bus_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_CONV = 4'b0100,
        ST_WAIT = 4'b1000
    } adsr_state_t;
endpackage

// ### verilog/adsr_ctrl.sv
/*
 * Converter control: register file, sequencer, halt handling, interrupt.
 * Assumes the CPU reports halt as a level and the analog channels
 * arrive as already-quantised 8-bit codes (ideal transfer, 1 step = Vref/256).
 */
// Strobed register access was chosen for this implementation.
// What this block does
// R1: Conversion may continue through halt only with RC clock select.
// R2: RC clock: wait one instruction cycle after go before converting.
// R3: On finish, clear go/done and load result register.
// R4: Finish during halt with done enable set wakes the device.
// R5: Finish during halt without enable: no wake, converter-on stays set.
// R6: Halt on non-RC clock aborts conversion and powers converter down.
// R7: That power-down leaves converter-on bit set.
// R8: Software sets RC clock, sets go, then halts to convert asleep.
// R9: Software picks a bit period of at least minimum, ideally <= 8 us.
// R10: Reset restores registers, switches converter off, aborts conversion.
// R11: Reset leaves result register unchanged.
// R12: Output code rises by one per input step of reference/256.
// R13: Unimplemented bits read as zero.
// R14: Core interrupt control reads and writes at both bank addresses.
// R15: Clock select 00/01/10/11 = 2, 8, 32 oscillator periods, RC.
// R16: One conversion lasts nine and a half bit periods.
// R17: Clearing go aborts, keeps result, then waits two bit periods.
// R18: Done flag sets together with go/done clearing.
// R19: Channel select routes input; go starts only with converter on.
module adsr_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic cpu_halted,
    input wire logic [7:0] ain0,
    input wire logic [7:0] ain1,
    input wire logic [7:0] ain2,
    input wire logic [7:0] ain3,
    output logic wake,
    output logic irq,
    output logic converter_powered
);
    adsr_pkg::adsr_bus_t bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    logic [7:0] conv_control;
    logic [7:0] core_irq_control;
    logic [7:0] periph_irq_flags;
    logic [7:0] periph_irq_enables;
    logic [7:0] analog_pin_config;
    logic [7:0] port_direction;
    logic [7:0] conv_result;
    logic [7:0] sample;
    adsr_pkg::adsr_state_t state;
    logic [adsr_pkg::CNT_W-1:0] tick_cnt;
    logic [4:0] half_cnt;
    logic half_tick;

    logic [1:0] conv_clock_select;
    logic [1:0] channel_select;
    logic converter_on;
    logic go_bit;
    logic is_rc;
    logic halt_kill;
    logic done_evt;
    logic go_cleared_by_sw;
    logic wr_ctl;
    logic [adsr_pkg::CNT_W-1:0] half_len;
    logic delay_over;
    logic go_refused;
    logic phase_start;
    logic [7:0] chan_in [4];
    logic [7:0] chan_gated [4];
    logic [7:0] routed;

    assign conv_clock_select = conv_control[adsr_pkg::CTL_CONV_CLOCK_SELECT_LO +: 2];
    assign channel_select = conv_control[adsr_pkg::CTL_CHS_LO +: 2];
    assign converter_on = conv_control[adsr_pkg::CTL_ON];
    assign go_bit = conv_control[adsr_pkg::CTL_GO];
    assign is_rc = (conv_clock_select == adsr_pkg::CONV_CLOCK_SELECT_RC);
    assign halt_kill = cpu_halted && !is_rc; // [R1] [R6]
    assign wr_ctl = bus.wr && bus.addr == adsr_pkg::ADDR_CONTROL;
    // Switching the converter off mid-conversion aborts it like a go clear
    assign go_cleared_by_sw = wr_ctl
        && (!bus.wdata[adsr_pkg::CTL_GO] || !bus.wdata[adsr_pkg::CTL_ON]);
    // Go that nothing would act on is dropped, or it would stay set forever
    assign go_refused = state == adsr_pkg::ST_WAIT
        || (state == adsr_pkg::ST_IDLE && halt_kill);
    assign delay_over = !is_rc || tick_cnt == adsr_pkg::CNT_W'(adsr_pkg::INSTR_CYC - 1); // [R2]
    // Prescaler restarts at each phase so every half period is whole [R16] [R17]
    assign phase_start = (state == adsr_pkg::ST_DELAY && delay_over)
        || (state == adsr_pkg::ST_CONV && go_cleared_by_sw);
    assign done_evt = rst_n && (state == adsr_pkg::ST_CONV) && half_tick
        && half_cnt == 5'(adsr_pkg::HALF_TADS - 1) && !go_cleared_by_sw && !halt_kill;

    // Channel routing: one gated copy per input, ORed together [R19]
    assign chan_in[0] = ain0;
    assign chan_in[1] = ain1;
    assign chan_in[2] = ain2;
    assign chan_in[3] = ain3;
    for (genvar c = 0; c < 4; c++) begin : g_chan
        assign chan_gated[c] = (channel_select == 2'(c)) ? chan_in[c] : 8'h00;
    end
    assign routed = chan_gated[0] | chan_gated[1] | chan_gated[2] | chan_gated[3];

    // Half bit period length per clock select [R15]
    always_comb begin
        case (conv_clock_select)
            adsr_pkg::CONV_CLOCK_SELECT_2: half_len = adsr_pkg::CNT_W'(adsr_pkg::TOSC_CYC);
            adsr_pkg::CONV_CLOCK_SELECT_8: half_len = adsr_pkg::CNT_W'(4 * adsr_pkg::TOSC_CYC);
            adsr_pkg::CONV_CLOCK_SELECT_32: half_len = adsr_pkg::CNT_W'(16 * adsr_pkg::TOSC_CYC);
            default: half_len = adsr_pkg::CNT_W'(adsr_pkg::RC_TAD_CYC / 2);
        endcase
    end

    assign half_tick = (tick_cnt >= half_len - 1'b1);

    // Bit-period prescaler
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_cnt <= '0;
        end else if (half_tick || phase_start || state == adsr_pkg::ST_IDLE) begin
            tick_cnt <= '0; // [R16]
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // Half bit periods of the running phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            half_cnt <= '0;
        end else begin
            case (state)
                adsr_pkg::ST_CONV: begin
                    if (go_cleared_by_sw) begin
                        half_cnt <= '0; // [R17]
                    end else if (half_tick) begin
                        half_cnt <= half_cnt + 1'b1; // [R16]
                    end
                end
                adsr_pkg::ST_WAIT: begin
                    if (half_tick) begin
                        half_cnt <= half_cnt + 1'b1;
                    end
                end
                default: half_cnt <= '0;
            endcase
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= adsr_pkg::ST_IDLE; // [R10]
        end else begin
            case (state)
                adsr_pkg::ST_IDLE: begin
                    if (wr_ctl && bus.wdata[adsr_pkg::CTL_GO] && bus.wdata[adsr_pkg::CTL_ON]
                        && converter_on && !halt_kill) begin // [R19]
                        state <= adsr_pkg::ST_DELAY;
                    end
                end
                adsr_pkg::ST_DELAY: begin
                    // Lets the halt instruction retire before sampling [R2]
                    if (halt_kill || go_cleared_by_sw) begin
                        state <= adsr_pkg::ST_IDLE;
                    end else if (delay_over) begin
                        state <= adsr_pkg::ST_CONV;
                    end
                end
                adsr_pkg::ST_CONV: begin
                    if (halt_kill) begin
                        state <= adsr_pkg::ST_IDLE; // [R6]
                    end else if (go_cleared_by_sw) begin
                        state <= adsr_pkg::ST_WAIT; // [R17]
                    end else if (done_evt) begin
                        state <= adsr_pkg::ST_IDLE; // [R16]
                    end
                end
                adsr_pkg::ST_WAIT: begin
                    // Holding cap disconnected until the wait ends [R17]
                    if (half_tick && half_cnt == 5'(adsr_pkg::WAIT_HALF_TADS - 1)) begin
                        state <= adsr_pkg::ST_IDLE;
                    end
                end
                default: state <= adsr_pkg::ST_IDLE;
            endcase
        end
    end

    // Sample the routed channel at conversion start [R19]
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sample <= 8'h00;
        end else if (state == adsr_pkg::ST_DELAY) begin
            sample <= routed;
        end
    end

    // Control register; go/done cleared by hardware on finish [R3]
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_control <= adsr_pkg::RST_CONTROL; // [R10]
        end else begin
            if (wr_ctl) begin
                conv_control <= bus.wdata & adsr_pkg::MASK_CONTROL;
                if (!bus.wdata[adsr_pkg::CTL_ON] || !converter_on || go_refused) begin
                    conv_control[adsr_pkg::CTL_GO] <= 1'b0; // [R19]
                end
            end
            if (done_evt || (halt_kill && state != adsr_pkg::ST_IDLE)) begin
                // Converter-on untouched on abort or finish [R5] [R7]
                conv_control[adsr_pkg::CTL_GO] <= 1'b0; // [R3]
            end
        end
    end

    // Result register keeps its value through reset [R11]
    always_ff @(posedge clk) begin
        if (done_evt) begin
            conv_result <= sample; // [R3] [R12]
        end else if (rst_n && bus.wr && bus.addr == adsr_pkg::ADDR_RESULT) begin
            conv_result <= bus.wdata;
        end
    end

    // Done flag: set wins over software clear [R18]
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            periph_irq_flags <= adsr_pkg::RST_FLAGS;
        end else if (done_evt) begin
            periph_irq_flags[adsr_pkg::FLG_DONE] <= 1'b1; // [R18]
        end else if (bus.wr && bus.addr == adsr_pkg::ADDR_IRQ_FLAGS) begin
            periph_irq_flags <= periph_irq_flags & ~(bus.wdata & adsr_pkg::MASK_FLAGS);
        end
    end

    // Remaining software registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_irq_control <= adsr_pkg::RST_CORE;
            periph_irq_enables <= adsr_pkg::RST_IRQ_EN;
            analog_pin_config <= adsr_pkg::RST_PIN_CFG;
            port_direction <= adsr_pkg::RST_PORT_DIR;
        end else if (bus.wr) begin
            if (bus.addr == adsr_pkg::ADDR_CORE_IRQ
                || bus.addr == adsr_pkg::ADDR_CORE_IRQ_HI) begin
                core_irq_control <= bus.wdata; // [R14]
            end
            if (bus.addr == adsr_pkg::ADDR_IRQ_EN) begin
                periph_irq_enables <= bus.wdata & adsr_pkg::MASK_FLAGS; // [R13]
            end
            if (bus.addr == adsr_pkg::ADDR_PIN_CFG) begin
                analog_pin_config <= bus.wdata & adsr_pkg::MASK_PIN_CFG; // [R13]
            end
            if (bus.addr == adsr_pkg::ADDR_PORT_DIR) begin
                port_direction <= bus.wdata & adsr_pkg::MASK_PORT_DIR; // [R13]
            end
        end
    end

    // Read port, one cycle latency; unmapped reads zero [R13]
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                adsr_pkg::ADDR_CORE_IRQ, adsr_pkg::ADDR_CORE_IRQ_HI: begin
                    rdata <= core_irq_control; // [R14]
                end
                adsr_pkg::ADDR_IRQ_FLAGS: rdata <= periph_irq_flags;
                adsr_pkg::ADDR_IRQ_EN: rdata <= periph_irq_enables;
                adsr_pkg::ADDR_RESULT: rdata <= conv_result;
                adsr_pkg::ADDR_CONTROL: rdata <= conv_control;
                adsr_pkg::ADDR_PIN_CFG: rdata <= analog_pin_config;
                adsr_pkg::ADDR_PORT_DIR: rdata <= port_direction;
                adsr_pkg::ADDR_PORT_PINS: rdata <= 8'h00; // Analog pins read low
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Wake and interrupt outputs [R4] [R5]
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake <= 1'b0;
            irq <= 1'b0;
            converter_powered <= 1'b0;
        end else begin
            wake <= cpu_halted && done_evt && periph_irq_enables[adsr_pkg::FLG_DONE]; // [R4]
            irq <= core_irq_control[adsr_pkg::CORE_GIE] && core_irq_control[adsr_pkg::CORE_PERIPH_IRQ_EN]
                && |(periph_irq_flags & periph_irq_enables);
            converter_powered <= converter_on && !halt_kill; // [R6]
        end
    end
endmodule

// ### tb/adsr_ctrl_properties.sv
/* Port-level checker for adsr_ctrl.
   Assumes it is bound to adsr_ctrl, one clk domain, sync active-low rst_n. */
module adsr_ctrl_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic cpu_halted,
    input wire logic wake,
    input wire logic irq,
    input wire logic converter_powered
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CTL = adsr_pkg::ADDR_CONTROL;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rc_on;
        wr && addr == CTL && wdata[0] && wdata[7:6] == adsr_pkg::CONV_CLOCK_SELECT_RC ##1 !wr [*2];
    endsequence
    sequence s_fast_on;
        wr && addr == CTL && wdata[0] && wdata[7:6] != adsr_pkg::CONV_CLOCK_SELECT_RC ##1 !wr [*2];
    endsequence
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_ctl_reserved: assert property ($past(rd) && $past(addr) == CTL |->
        rdata[5] == 1'b0 && rdata[1] == 1'b0) else $error("reserved control bit set");
    chk_flag_reserved: assert property ($past(rd) && $past(addr) == 8'h0C |->
        (rdata & ~adsr_pkg::MASK_FLAGS) == 8'h00) else $error("unused flag bit set");
    chk_wake_cause: assert property (wake |-> $past(cpu_halted))
        else $error("wake outside halt");
    chk_wake_pulse: assert property (wake |=> !wake)
        else $error("wake longer than one cycle");
    chk_reset_off: assert property (disable iff (1'b0) !rst_n |=>
        !converter_powered && !irq && !wake) else $error("outputs active after reset");
    chk_power_off: assert property (wr && addr == CTL && !wdata[0] |->
        ##[1:2] !converter_powered) else $error("converter powered while off");
    chk_halt_rc: assert property (s_rc_on ##1 cpu_halted |-> converter_powered)
        else $error("RC converter lost power in halt");
    chk_halt_fast: assert property (s_fast_on ##1 (cpu_halted && !wr) [*3] |->
        !converter_powered) else $error("converter still powered in halt");
endmodule

// ### tb/adsr_ctrl_tb.sv
/* Self-checking bench for adsr_ctrl: reset values, all channels and clock
   selects, interrupt, abort, halt handling and reset.
   Assumes the register port contract of the block and a 50 MHz clock. */
module adsr_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CTL = adsr_pkg::ADDR_CONTROL;
    localparam logic [7:0] RES = adsr_pkg::ADDR_RESULT;
    localparam logic [7:0] FLG = adsr_pkg::ADDR_IRQ_FLAGS;
    // Go edge to irq, 8-period clock: one delay cycle, 19 halves of 4, irq register
    localparam int CONV_CYC_8 = 2 + adsr_pkg::HALF_TADS * 4 * adsr_pkg::TOSC_CYC;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cpu_halted = 1'b0;
    logic [7:0] ain [4] = '{8'h5A, 8'hA5, 8'h01, 8'hFF};
    logic [7:0] rdata;
    logic wake, irq, converter_powered;
    logic [7:0] d;
    logic [7:0] ra [9] = '{8'h0B, 8'h8B, 8'h0C, 8'h8C, 8'h1F, 8'h9F, 8'h85, 8'h05, 8'h40};
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00};
    int bad_count = 0;
    int n_compared = 0;
    int wake_cnt = 0;
    int k;

    adsr_ctrl i_adsr_ctrl (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .cpu_halted(cpu_halted), .ain0(ain[0]), .ain1(ain[1]),
        .ain2(ain[2]), .ain3(ain[3]), .wake(wake), .irq(irq),
        .converter_powered(converter_powered));

    initial forever #10 clk = ~clk;
    always @(posedge clk) if (wake === 1'b1) wake_cnt <= wake_cnt + 1;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        rd_reg(a, d);
        chk(d, exp, what);
    endtask
    // Turn on first, go in a later write: go with the same write would be dropped
    task automatic start(input logic [7:0] ctl);
        wr_reg(CTL, ctl);
        wr_reg(CTL, ctl | 8'h04);
    endtask
    task automatic wait_done();
        d = 8'h04;
        for (int i = 0; i < 1500 && d[2] !== 1'b0; i++)
            rd_reg(CTL, d);
    endtask
    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd_chk(ra[i], rv[i], "reset value");
        wr_reg(8'h8B, 8'hC0);
        rd_chk(8'h0B, 8'hC0, "core irq other bank");
        wr_reg(CTL, 8'hFF);
        rd_chk(CTL, 8'hD9, "go while off");
        wr_reg(CTL, 8'h00);
        wr_reg(8'h8C, 8'h40);
        $display("test registers done");
        for (int ch = 0; ch < 4; ch++) begin
            start({ch[1:0], 1'b0, ch[1:0], 3'b001});
            wait_done();
            chk(d, {ch[1:0], 1'b0, ch[1:0], 3'b001}, "go cleared");
            rd_chk(RES, ain[ch], "result");
            rd_chk(FLG, 8'h40, "done flag");
            chk({7'h00, irq}, 8'h01, "irq raised");
            wr_reg(FLG, 8'h40);
            repeat (2) @(posedge clk);
            #1 chk({7'h00, irq}, 8'h00, "irq cleared");
        end
        start(8'h41);
        for (k = 0; k < 200 && irq !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk(8'(k), 8'(CONV_CYC_8), "conversion time");
        wr_reg(FLG, 8'h40);
        wr_reg(8'h8C, 8'h00);
        start(8'h01);
        wait_done();
        chk({7'h00, irq}, 8'h00, "irq masked");
        wr_reg(FLG, 8'h40);
        $display("test conversions done");
        start(8'h81);
        repeat (20) @(posedge clk);
        ain[0] <= 8'h33;
        wr_reg(CTL, 8'h81);
        rd_chk(RES, 8'h5A, "abort keeps result");
        rd_chk(FLG, 8'h00, "abort no flag");
        repeat (100) @(posedge clk);
        start(8'h81);
        cpu_halted <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk({7'h00, converter_powered}, 8'h00, "halt powers down");
        rd_chk(CTL, 8'h81, "halt keeps on bit");
        rd_chk(RES, 8'h5A, "halt abort result");
        cpu_halted <= 1'b0;
        $display("test abort done");
        wr_reg(8'h8C, 8'h40);
        start(8'hC1);
        cpu_halted <= 1'b1;
        k = wake_cnt;
        repeat (3) @(posedge clk);
        #1 chk({7'h00, converter_powered}, 8'h01, "RC runs in halt");
        for (int i = 0; i < 3000 && wake_cnt == k; i++)
            @(posedge clk);
        chk(8'(wake_cnt - k), 8'h01, "wake on done");
        cpu_halted <= 1'b0;
        rd_chk(RES, 8'h33, "halt result");
        wr_reg(FLG, 8'h40);
        wr_reg(8'h8C, 8'h00);
        start(8'hC1);
        cpu_halted <= 1'b1;
        k = wake_cnt;
        repeat (2200) @(posedge clk);
        chk(8'(wake_cnt - k), 8'h00, "no wake masked");
        rd_chk(CTL, 8'hC1, "on stays set");
        cpu_halted <= 1'b0;
        $display("test halt done");
        ain[0] <= 8'h77;
        start(8'h81);
        repeat (10) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(CTL, 8'h00, "reset aborts");
        rd_chk(RES, 8'h33, "reset keeps result");
        chk({7'h00, converter_powered}, 8'h00, "reset powers off");
        $display("test reset done");
        end_sim();
    end
endmodule

bind adsr_ctrl adsr_ctrl_props i_adsr_ctrl_props (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cpu_halted(cpu_halted), .wake(wake),
    .irq(irq), .converter_powered(converter_powered));
